// *** hw/ldf_pkg.sv ***
// Purpose: Shared constants and types of the LED dimming and fault status block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: 16-bit registers sit in the low half of each word
package ldf_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned AW = 8;
  localparam int unsigned GS_DIV_DEF = 8; // 125 MHz / 8 = 15.6 MHz

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CFG0 = 8'h00;
  localparam logic [7:0] OFS_CFG1 = 8'h04;
  localparam logic [7:0] OFS_LAT = 8'h08;
  localparam logic [7:0] OFS_CHEN = 8'h0C;
  localparam logic [7:0] OFS_FSTAT = 8'h10;
  localparam logic [1:0] BRT_PAGE = 2'h1; // 0x40..0x7C, one word each

  // ==========================================================
  // Field positions
  localparam int unsigned CFG0_EN = 0;
  localparam int unsigned CFG0_GRAYSCALE_MODE_SELECT = 4;
  localparam int unsigned CFG0_FLAG_LSB = 12;
  localparam int unsigned CFG1_LAT16 = 7;
  localparam int unsigned CFG1_LAT17 = 8;
  localparam int unsigned CFG1_BRIGHTNESS_LENGTH_SELECT = 10;
  localparam int unsigned CFG1_DTIN = 11;
  localparam int unsigned CFG1_SYNC_DIRECTION_SELECT = 13;
  localparam logic [15:0] CFG0_LOCK = 16'h000C; // current range, third locked bit
  localparam logic [15:0] CFG1_LOCK = 16'h2000; // sync direction
  localparam logic [15:0] CFG0_RO = 16'hF000;

  // ==========================================================
  // Reset values
  localparam logic [15:0] CFG0_RST = 16'h0002;
  localparam logic [15:0] CFG1_RST = 16'h0040;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // ==========================================================
  // Dimming timing, in grayscale clock periods
  localparam logic [16:0] SPAN12 = 17'h0_1000;
  localparam logic [16:0] SPAN16 = 17'h1_0000;
  localparam logic [17:0] LAST12 = 18'h0_0FFF;
  localparam logic [17:0] LAST16 = 18'h0_FFFF;
  localparam logic [2:0] SYNC_OUT_TICKS = 3'h4;

  // ==========================================================
  // Bus answers and sequence states
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SEQ_OFF, SEQ_LAT, SEQ_DIM, SEQ_WAIT} ldf_seq_t;
endpackage

// *** hw/ldf_gs_tick.sv ***
// Purpose: Grayscale clock enable, from internal divider or from the clock pin
// Assumes: Pin input synchronous to the core clock
// Notes: Tick is a one-cycle pulse per grayscale period
module ldf_gs_tick import ldf_pkg::*; #(
  parameter int unsigned DIV = GS_DIV_DEF
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Source select and external clock
  input wire logic i_ext_sel,
  input wire logic i_ext_clk,
  // Tick and clock for the pin
  output logic o_tick,
  output logic o_clk_out
);
  localparam int unsigned HALF = DIV / 2;
  localparam int unsigned CW = $clog2(HALF + 1);

  generate if (DIV < 2 || DIV % 2 != 0) begin : g_chk
    $error("grayscale divider must be even and at least 2");
  end endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic lvl;
    logic ext_q;
    logic tick;
  } ldf_tick_st_t;

  ldf_tick_st_t s;
  ldf_tick_st_t n;

  // ==========================================================
  // Next state: external edge or divider half-period
  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.ext_q = i_ext_clk;
    if (i_ext_sel) begin
      // Oscillator stopped, pin is the clock
      n.cnt = '0;
      n.lvl = 1'b0;
      n.tick = i_ext_clk & ~s.ext_q;
    end else if (s.cnt == CW'(HALF - 1)) begin
      n.cnt = '0;
      n.lvl = ~s.lvl;
      n.tick = ~s.lvl; // One tick per full period
    end else begin
      n.cnt = s.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_tick = s.tick;
  assign o_clk_out = s.lvl;
endmodule

// *** hw/ldf_chan_pwm.sv ***
// Purpose: One channel PWM comparator with registered output
// Assumes: Phase counts grayscale clocks from the start of the dimming period
// Notes: Inverted timing puts the off-phase first
module ldf_chan_pwm import ldf_pkg::*; (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Dimming controls
  input wire logic i_active,
  input wire logic i_brightness_length_select,
  input wire logic i_dtin,
  input wire logic [15:0] i_phase,
  input wire logic [15:0] i_duty,
  // Channel drive
  output logic o_on
);
  typedef struct packed {
    logic on;
  } ldf_chan_st_t;

  ldf_chan_st_t s;
  ldf_chan_st_t n;
  logic [15:0] duty;
  logic [16:0] span;

  // ==========================================================
  // Compare phase with duty at the chosen resolution
  always_comb begin
    duty = i_brightness_length_select ? i_duty : {4'h0, i_duty[11:0]};
    span = i_brightness_length_select ? SPAN16 : SPAN12;
    n.on = i_active & (i_dtin ? ({1'b0, i_phase} >= span - {1'b0, duty})
                              : (i_phase < duty));
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_on = s.on;
endmodule

// *** hw/ldf_top.sv ***
// Purpose: Dimming control and channel fault status of a 16-channel LED driver
// Assumes: Pins and fault detector inputs synchronous to i_core_clk
// Notes: Registers over AXI4-Lite; analog detection lives outside
module ldf_top import ldf_pkg::*; #(
  parameter int unsigned GS_DIV = GS_DIV_DEF
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // AXI4-Lite write channels
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // AXI4-Lite read channels
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [AW-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Fault detector and analog flags
  input wire logic i_detect_done,
  input wire logic [NUM_CH-1:0] i_detect_fault,
  input wire logic i_crit_fault,
  input wire logic i_out_reg_ok,
  input wire logic i_dac_overflow,
  input wire logic i_fourth_status,
  // Grayscale clock pin and oscillator setting pin
  input wire logic i_osc_setting_pin,
  input wire logic i_gs_clk_pin_i,
  output logic o_gs_clk_pin_o,
  output logic o_gs_clk_pin_oe,
  // Grayscale sync pin
  input wire logic i_gs_sync_pin_i,
  output logic o_gs_sync_pin_o,
  output logic o_gs_sync_pin_oe,
  // Fault flag pin, open drain, active low
  output logic o_fault_flag_pin_n_o,
  output logic o_fault_flag_pin_n_oe,
  // Channel current generator enables
  output logic [NUM_CH-1:0] o_chan_on
);
  generate if (NUM_CH != 16) begin : g_chk
    $error("brightness page decode serves exactly 16 channels");
  end endgenerate

  typedef struct packed {
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    logic [15:0] lat;
    logic [15:0] chen;
    logic [15:0] fstat;
    logic [NUM_CH-1:0][15:0] bright;
    ldf_seq_t seq;
    logic [17:0] cnt;
    logic [2:0] sync_cnt;
    logic [2:0] sync_hi;
    logic sync_q;
    logic sync_o;
    logic sync_oe;
    logic grayscale_clock_pin_oe;
    logic flt_oe;
    logic aw_v;
    logic [AW-1:0] aw_a;
    logic w_v;
    logic [15:0] w_d;
    logic [1:0] w_s;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] bresp;
    logic arr;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rresp;
  } ldf_st_t;

  ldf_st_t s;
  ldf_st_t n;
  logic tick;
  logic en;
  logic sync_direction_select;
  logic grayscale_mode_select;
  logic run;
  logic [NUM_CH-1:0] ch_on;

  // Merge the two low byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  assign en = s.cfg0[CFG0_EN];
  assign sync_direction_select = s.cfg1[CFG1_SYNC_DIRECTION_SELECT];
  assign grayscale_mode_select = s.cfg0[CFG0_GRAYSCALE_MODE_SELECT];
  assign run = en && (s.seq == SEQ_DIM);

  // ==========================================================
  // Grayscale clock source
  ldf_gs_tick #(
    .DIV(GS_DIV)
  ) u_tick (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ext_sel(i_osc_setting_pin),
    .i_ext_clk(i_gs_clk_pin_i),
    .o_tick(tick),
    .o_clk_out(o_gs_clk_pin_o)
  );

  // ==========================================================
  // Channel PWM, one comparator per channel
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    ldf_chan_pwm u_pwm (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_active(run & s.chen[g]),
      .i_brightness_length_select(s.cfg1[CFG1_BRIGHTNESS_LENGTH_SELECT]),
      .i_dtin(s.cfg1[CFG1_DTIN]),
      .i_phase(s.cnt[15:0]),
      .i_duty(grayscale_mode_select ? s.bright[g] : s.bright[0]),
      .o_on(ch_on[g])
    );
  end

  // ==========================================================
  // Next state: bus, registers, sequence, sync and fault
  always_comb begin
    logic [7:0] wa;
    logic [7:0] ra;
    logic [15:0] wv;
    logic [15:0] rv16;
    logic [17:0] latency;
    logic [17:0] last;
    logic hit;
    logic rhit;
    logic end_cyc;
    logic rise;
    logic fall;
    logic skip_lat;
    wa = {s.aw_a[7:2], 2'b00};
    ra = {i_s_axi_araddr[7:2], 2'b00};
    wv = merge16(16'h0000, s.w_d, s.w_s);
    rv16 = ZERO16;
    latency = {s.cfg1[CFG1_LAT17], s.cfg1[CFG1_LAT16], s.lat};
    last = s.cfg1[CFG1_BRIGHTNESS_LENGTH_SELECT] ? LAST16 : LAST12;
    skip_lat = (latency == 18'h0_0000); // Zero latency goes straight to dimming
    hit = 1'b1;
    rhit = 1'b1;
    end_cyc = 1'b0;
    rise = i_gs_sync_pin_i & ~s.sync_q;
    fall = ~i_gs_sync_pin_i & s.sync_q;
    n = s;
    n.sync_q = i_gs_sync_pin_i;

    // Write address and data taken in either order
    if (i_s_axi_awvalid && s.awr) begin
      n.aw_v = 1'b1;
      n.aw_a = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && s.wr) begin
      n.w_v = 1'b1;
      n.w_d = i_s_axi_wdata[15:0];
      n.w_s = i_s_axi_wstrb[1:0];
    end
    if (s.bv && i_s_axi_bready) begin
      n.bv = 1'b0;
    end
    if (s.aw_v && s.w_v && !s.bv) begin
      n.aw_v = 1'b0;
      n.w_v = 1'b0;
      n.bv = 1'b1;
      unique case (wa)
        OFS_CFG0: begin
          wv = merge16(s.cfg0, s.w_d, s.w_s);
          if (en) begin
            wv = (wv & ~CFG0_LOCK) | (s.cfg0 & CFG0_LOCK);
          end
          n.cfg0 = (wv & ~CFG0_RO) | (s.cfg0 & CFG0_RO);
        end
        OFS_CFG1: begin
          wv = merge16(s.cfg1, s.w_d, s.w_s);
          if (en) begin
            wv = (wv & ~CFG1_LOCK) | (s.cfg1 & CFG1_LOCK);
          end
          n.cfg1 = wv;
        end
        OFS_LAT: n.lat = merge16(s.lat, s.w_d, s.w_s);
        OFS_CHEN: n.chen = merge16(s.chen, s.w_d, s.w_s);
        OFS_FSTAT: hit = 1'b1; // Read only, write dropped
        default: begin
          if (wa[7:6] == BRT_PAGE) begin
            n.bright[wa[5:2]] = merge16(s.bright[wa[5:2]], s.w_d, s.w_s);
          end else begin
            hit = 1'b0;
          end
        end
      endcase
      n.bresp = hit ? RESP_OKAY : RESP_SLVERR;
    end
    n.awr = !n.aw_v && !n.bv;
    n.wr = !n.w_v && !n.bv;

    // Read: one outstanding, answer one cycle after the address
    if (s.rv && i_s_axi_rready) begin
      n.rv = 1'b0;
    end
    if (i_s_axi_arvalid && s.arr) begin
      unique case (ra)
        OFS_CFG0: rv16 = s.cfg0;
        OFS_CFG1: rv16 = s.cfg1;
        OFS_LAT: rv16 = ZERO16; // Write-only latency
        OFS_CHEN: rv16 = s.chen;
        OFS_FSTAT: rv16 = s.fstat;
        default: begin
          if (ra[7:6] == BRT_PAGE) begin
            rv16 = s.bright[ra[5:2]];
          end else begin
            rhit = 1'b0;
          end
        end
      endcase
      n.rv = 1'b1;
      n.rd = {16'h0000, rv16};
      n.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
    end
    n.arr = !n.rv;

    // Read-only flags follow the analog side only while enabled
    if (n.cfg0[CFG0_EN]) begin
      n.cfg0[CFG0_FLAG_LSB +: 4] = {i_fourth_status, i_dac_overflow, i_out_reg_ok,
                                    i_crit_fault};
    end else begin
      n.cfg0[CFG0_FLAG_LSB +: 4] = 4'h0;
    end

    // Latency then dimming, counted in grayscale ticks
    unique case (s.seq)
      SEQ_OFF: begin
        n.seq = sync_direction_select ? SEQ_WAIT : (skip_lat ? SEQ_DIM : SEQ_LAT);
        n.cnt = '0;
      end
      // Leave on the last latency tick, so phase zero gets a whole period
      SEQ_LAT: begin
        if (tick && (s.cnt + 18'h0_0001 >= latency)) begin
          n.seq = SEQ_DIM;
          n.cnt = '0;
        end else if (tick) begin
          n.cnt = s.cnt + 18'h0_0001;
        end
      end
      SEQ_DIM: begin
        if (tick && s.cnt == last) begin
          end_cyc = 1'b1;
          n.seq = sync_direction_select ? SEQ_WAIT : (skip_lat ? SEQ_DIM : SEQ_LAT);
          n.cnt = '0;
        end else if (tick) begin
          n.cnt = s.cnt + 18'h0_0001;
        end
      end
      SEQ_WAIT: n.cnt = '0;
    endcase
    // Input sync: rise aborts, fall starts a fresh cycle
    if (sync_direction_select && rise) begin
      n.seq = SEQ_WAIT;
      n.cnt = '0;
    end else if (sync_direction_select && fall) begin
      n.seq = skip_lat ? SEQ_DIM : SEQ_LAT;
      n.cnt = '0;
    end
    if (!en) begin
      n.seq = SEQ_OFF;
      n.cnt = '0;
    end

    // End-of-cycle pulse; a restart never cuts it short
    if (end_cyc && !sync_direction_select) begin
      n.sync_cnt = SYNC_OUT_TICKS;
    end else if (tick && s.sync_cnt != 3'h0) begin
      n.sync_cnt = s.sync_cnt - 3'h1;
    end
    if (sync_direction_select) begin
      n.sync_cnt = 3'h0;
    end
    n.sync_o = (n.sync_cnt != 3'h0);
    n.sync_hi = s.sync_o ? s.sync_hi + {2'h0, tick} : 3'h0;
    n.sync_oe = !sync_direction_select;
    n.grayscale_clock_pin_oe = !i_osc_setting_pin;

    // Fault status: fresh word per detection, masked channels forced low
    if (!n.cfg0[CFG0_EN]) begin
      n.fstat = ZERO16;
    end else if (i_detect_done) begin
      n.fstat = i_detect_fault & n.chen;
    end else begin
      n.fstat = s.fstat & n.chen;
    end
    n.flt_oe = (n.fstat != ZERO16);
  end

  // ==========================================================
  // State register, power-on values
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
      s.cfg0 <= CFG0_RST;
      s.cfg1 <= CFG1_RST;
      s.seq <= SEQ_OFF;
      s.awr <= 1'b1;
      s.wr <= 1'b1;
      s.arr <= 1'b1;
      s.grayscale_clock_pin_oe <= 1'b0;
    end else begin
      s <= n;
    end
  end

  // Outputs, straight from flops except the fault pin level, tied low
  assign o_s_axi_awready = s.awr;
  assign o_s_axi_wready = s.wr;
  assign o_s_axi_bvalid = s.bv;
  assign o_s_axi_bresp = s.bresp;
  assign o_s_axi_arready = s.arr;
  assign o_s_axi_rvalid = s.rv;
  assign o_s_axi_rdata = s.rd;
  assign o_s_axi_rresp = s.rresp;
  assign o_gs_clk_pin_oe = s.grayscale_clock_pin_oe;
  assign o_gs_sync_pin_o = s.sync_o;
  assign o_gs_sync_pin_oe = s.sync_oe;
  assign o_fault_flag_pin_n_o = 1'b0; // Open drain only ever pulls low
  assign o_fault_flag_pin_n_oe = s.flt_oe;
  assign o_chan_on = ch_on;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  masked_zero_a: assert property ((s.fstat & ~s.chen) == ZERO16)
    else $error("fault status set on a disabled channel");
  overwrite_a: assert property (i_detect_done |=> !en ||
      (s.fstat == ($past(i_detect_fault) & s.chen)))
    else $error("fault status not replaced by detection result");
  fault_pin_a: assert property (s.flt_oe == (s.fstat != ZERO16))
    else $error("fault pin disagrees with status word");
  disable_clear_a: assert property (!en |-> s.fstat == ZERO16 && !s.flt_oe
      && s.cfg0[15:12] == 4'h0)
    else $error("disable did not clear status");
  lock_bits_a: assert property (en |=>
      ((s.cfg0 & CFG0_LOCK) == $past(s.cfg0 & CFG0_LOCK))
      && (s.cfg1[CFG1_SYNC_DIRECTION_SELECT] == $past(s.cfg1[CFG1_SYNC_DIRECTION_SELECT])))
    else $error("locked bit changed while enabled");
  gate_mask_a: assert property ((o_chan_on & ~$past(s.chen)) == ZERO16)
    else $error("channel on while masked");
  group_same_a: assert property ($past(!grayscale_mode_select)
      |-> o_chan_on == ZERO16 || o_chan_on == $past(s.chen))
    else $error("group mode channels differ");
  sync_width_a: assert property ($fell(s.sync_o) && en && !sync_direction_select
      |-> s.sync_hi == SYNC_OUT_TICKS)
    else $error("sync pulse not four grayscale periods");
  sync_abort_a: assert property (en && sync_direction_select && i_gs_sync_pin_i && !s.sync_q
      |=> s.seq == SEQ_WAIT ##1 !run)
    else $error("rising sync did not abort");
endmodule

// *** test/ldf_sync_host.sv ***
// Purpose: Video source model that drives the grayscale sync pin
// Assumes: Pulse length given in core cycles by W
// Notes: Idles low between pulses, as a vertical sync line does
module ldf_sync_host #(
  parameter int W = 4
) (
  // Clock and trigger
  input wire logic i_clk,
  input wire logic i_fire,
  // Sync line
  output logic o_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // ==========================================================
  // Pulse timer, W kept at two grayscale periods or more
  always @(posedge i_clk) begin
    if (i_fire) begin
      n <= W;
    end else if (n > 0) begin
      n <= n - 1;
    end
  end
  assign o_sync = (n > 0);
endmodule

// *** test/tb_top.sv ***
// Purpose: Self-checking bench of the LED dimming and fault status block
// Assumes: GS_DIV of 2, so a 12-bit period is 8192 core cycles
// Notes: Registers reached over AXI4-Lite only
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ldf_pkg::*;
  localparam int D = 2;
  localparam int P = 4096 * D;
  // ==========================================================
  // Signals
  logic clk = 0;
  logic rstn = 0;
  // Response readies stay high, so no strobe is ever lowered and raised in one step
  logic awv = 0, wv = 0, bq = 1, arv = 0, rq = 1;
  logic dd = 0, cf = 0, osc = 0, fire = 0;
  logic [7:0] aa = 0, ra = 0;
  logic [31:0] wd = 0;
  logic [15:0] df = 0;
  logic awr, wrd, bv, arr, rv, gco, gcoe, so, soe, fo, foe, hs, gw, sw, fw;
  logic [1:0] br, rr, rs;
  logic [31:0] rd;
  logic [15:0] con;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  // Clock
  always #4 clk = ~clk;
  // Pin levels; a released clock pin sees a toggling pattern
  assign gw = gcoe ? gco : cyc[0];
  assign sw = soe ? so : hs;
  assign fw = foe ? fo : 1'b1;
  // ==========================================================
  // Design and sync source
  ldf_top #(.GS_DIV(D)) DUT (.i_core_clk(clk), .i_resetn(rstn),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(aa),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(4'h3), .o_s_axi_bvalid(bv), .i_s_axi_bready(bq),
    .o_s_axi_bresp(br), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .i_s_axi_araddr(ra), .o_s_axi_rvalid(rv), .i_s_axi_rready(rq),
    .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .i_detect_done(dd),
    .i_detect_fault(df), .i_crit_fault(cf), .i_out_reg_ok(1'b0),
    .i_dac_overflow(1'b0), .i_fourth_status(1'b0),
    .i_osc_setting_pin(osc), .i_gs_clk_pin_i(gw), .o_gs_clk_pin_o(gco),
    .o_gs_clk_pin_oe(gcoe), .i_gs_sync_pin_i(sw), .o_gs_sync_pin_o(so),
    .o_gs_sync_pin_oe(soe), .o_fault_flag_pin_n_o(fo),
    .o_fault_flag_pin_n_oe(foe), .o_chan_on(con));
  ldf_sync_host #(.W(4 * D)) HOST (.i_clk(clk), .i_fire(fire), .o_sync(hs));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic ta, td;
    ta = 0;
    td = 0;
    awv <= 1;
    aa <= a;
    wv <= 1;
    wd <= {16'h0000, d};
    while (!(ta && td)) begin
      @(posedge clk);
      if (awr && !ta) begin
        ta = 1;
        awv <= 0;
      end
      if (wrd && !td) begin
        td = 1;
        wv <= 0;
      end
    end
    while (!bv) @(posedge clk);
    rs = br;
  endtask
  // Read and compare the low half word
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string n);
    arv <= 1;
    ra <= a;
    @(posedge clk);
    while (!arr) @(posedge clk);
    arv <= 0;
    while (!rv) @(posedge clk);
    rs = rr;
    chk("rresp", rs, RESP_OKAY);
    chk(n, rd, {16'h0000, e});
  endtask
  task automatic det(input logic [15:0] v);
    df <= v;
    dd <= 1;
    @(posedge clk);
    dd <= 0;
    repeat (2) @(posedge clk);
  endtask
  // Sync pulse, then cycles from its fall until channel 0 lights
  task automatic pulse(output int t);
    fire <= 1;
    @(posedge clk);
    fire <= 0;
    while (!hs) @(posedge clk);
    while (hs) @(posedge clk);
    chk("abort", con[0], 0);
    t = 0;
    while (!con[0] && t < 100) begin
      @(posedge clk);
      t++;
    end
    chk("restart", con[0], 1);
  endtask
  task automatic conclude;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdc(OFS_CFG0, 16'h0002, "cfg0");
    rdc(OFS_CFG1, 16'h0040, "cfg1");
    rdc(OFS_LAT, 16'h0000, "lat");
    rdc(OFS_CHEN, 16'h0000, "mask");
    rdc(OFS_FSTAT, 16'h0000, "fstat");
    rdc(8'h7C, 16'h0000, "brt15");
    wr(8'h20, 16'hFFFF);
    chk("bresp", rs, RESP_SLVERR);
  endtask
  task automatic t_fault;
    wr(OFS_CHEN, 16'h00FF);
    wr(OFS_CFG0, 16'h0003);
    cf <= 1;
    det(16'hF0F0);
    rdc(OFS_FSTAT, 16'h00F0, "fstat");
    chk("flag", fw, 0);
    rdc(OFS_CHEN, 16'h00FF, "mask");
    rdc(OFS_CFG0, 16'h1003, "cfg0");
    wr(OFS_FSTAT, 16'hFFFF);
    rdc(OFS_FSTAT, 16'h00F0, "fstat ro");
    det(16'h0101);
    rdc(OFS_FSTAT, 16'h0001, "fstat new");
    wr(OFS_CFG0, 16'h0002);
    rdc(OFS_FSTAT, 16'h0000, "fstat off");
    chk("flag off", fw, 1);
    rdc(OFS_CFG0, 16'h0002, "cfg0 off");
    rdc(OFS_CHEN, 16'h00FF, "mask off");
    cf <= 0;
  endtask
  task automatic t_osc;
    int t;
    logic p;
    osc <= 1;
    repeat (3) @(posedge clk);
    chk("grayscale_clock_pin in", gcoe, 0);
    osc <= 0;
    repeat (3) @(posedge clk);
    chk("grayscale_clock_pin out", gcoe, 1);
    t = 0;
    p = gco;
    repeat (8) begin
      @(posedge clk);
      t += int'(gco ^ p);
      p = gco;
    end
    chk("grayscale_clock_pin edges", t, 8);
  endtask
  // Whole-period counts of channel and sync high cycles
  task automatic cnt(output int c0, output int c1, output int c2, output int s);
    c0 = 0;
    c1 = 0;
    c2 = 0;
    s = 0;
    repeat (P) @(posedge clk);
    repeat (P) begin
      @(posedge clk);
      c0 += int'(con[0]);
      c1 += int'(con[1]);
      c2 += int'(con[2]);
      s += int'(so);
    end
  endtask
  task automatic t_dim;
    int c0, c1, c2, s;
    wr(8'h40, 16'hF800);
    wr(8'h44, 16'h0400);
    wr(OFS_CHEN, 16'h0003);
    wr(OFS_CFG0, 16'h0003);
    chk("sync oe", soe, 1);
    cnt(c0, c1, c2, s);
    chk("ch0", c0, 2048 * D);
    chk("ch1", c1, 2048 * D);
    chk("ch2", c2, 0);
    chk("sync", s, 4 * D);
    wr(OFS_CFG0, 16'h0013);
    cnt(c0, c1, c2, s);
    chk("ch1 gs", c1, 1024 * D);
    wr(OFS_CFG0, 16'h0002);
  endtask
  task automatic t_lock;
    wr(OFS_CFG0, 16'h0003);
    wr(OFS_CFG0, 16'h000F);
    rdc(OFS_CFG0, 16'h0003, "cfg0 lock");
    wr(OFS_CFG1, 16'h2040);
    rdc(OFS_CFG1, 16'h0040, "cfg1 lock");
    wr(OFS_CFG0, 16'h0002);
    wr(OFS_CFG1, 16'h2040);
    rdc(OFS_CFG1, 16'h2040, "cfg1");
  endtask
  task automatic t_sync;
    int t0, t1;
    wr(OFS_CFG0, 16'h0003);
    chk("sync in", soe, 0);
    pulse(t0);
    pulse(t0);
    wr(OFS_LAT, 16'h000A);
    pulse(t1);
    chk("latency", (t1 - t0 >= 10 * D - 1) && (t1 - t0 <= 10 * D + 1), 1);
  endtask
  // ==========================================================
  // Timeout and main sequence
  always @(posedge clk) begin
    cyc <= cyc + 1; // Nonblocking, so the clock pin pattern never races the design
    if (cyc > 60000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    t_reset();
    t_fault();
    t_osc();
    t_dim();
    t_lock();
    t_sync();
    conclude();
  end
endmodule
